// ### hdl/cfg_tail_regs.svh
`ifndef CFG_TAIL_REGS_SVH
`define CFG_TAIL_REGS_SVH

// byte offsets in configuration space
`define OFS_SUBSYS_VENDOR   8'h2c
`define OFS_SUBSYS_CODE     8'h2e
`define OFS_CAP_POINTER     8'h34
`define OFS_IRQ_ROUTING     8'h3c
`define OFS_IRQ_PIN         8'h3d
`define OFS_BURST_HINT      8'h3e
`define OFS_INTERVAL_HINT   8'h3f
`define OFS_TARGET_WAIT     8'h40
`define OFS_RERUN_LIMIT     8'h41

// fixed and reset values
`define CAP_POINTER_VAL     8'hdc
`define CAP_RSVD_MASK       8'hfc
`define IRQ_PIN_VAL         8'h01
`define IRQ_ROUTING_RST     8'h00
`define TARGET_WAIT_RST     8'h00
`define RERUN_LIMIT_RST     8'h80
`define OHCI_BURST_HINT     8'h01
`define EHCI_BURST_HINT     8'h02
`define OHCI_INTERVAL_HINT  8'h2a
`define EHCI_INTERVAL_HINT  8'h10
`define LIMIT_OFF           8'h00

// target-ready limit layout: 8 programmed bits over 5 zero bits
`define WAIT_LOW_ZEROS      5'h00
`define WAIT_CNT_MAX        13'h1fff
`define RERUN_CNT_MAX       8'hff

// hint timing
`define HINT_UNIT_NS        250
`define CLK_PERIOD_NS       4
`define HINT_UNIT_CYC       (`HINT_UNIT_NS / `CLK_PERIOD_NS)

`define ZERO_BYTE           8'h00
`define ZERO_HALF           16'h0000

`endif

// ### hdl/cfg_tail_pkg.sv
package cfg_tail_pkg;

   typedef struct packed {
      logic [7:0]  irq_routing_number;
      logic [7:0]  target_wait_limit;
      logic [7:0]  rerun_limit;
      logic [31:0] rdata;
      logic        ack;
      logic        fatal_bus_error_flag;
      logic        capability_list_flag;
      logic [15:0] burst_cyc;
      logic [15:0] interval_cyc;
      logic        latency_demand;
   } bank_state_t;

   typedef struct packed {
      logic [12:0] wait_cnt;
      logic [7:0]  rerun_cnt;
      logic        wait_fired;
      logic        rerun_fired;
      logic        wait_expired;
      logic        rerun_expired;
   } sup_state_t;

endpackage : cfg_tail_pkg

// ### hdl/wait_supervisor.sv
`timescale 1ns/100ps
`include "cfg_tail_regs.svh"

module wait_supervisor (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic [7:0] target_wait_limit_i,
   input  wire logic [7:0] rerun_limit_i,
   input  wire logic       trdy_wait_i,
   input  wire logic       retry_i,
   input  wire logic       xfer_done_i,
   output logic            wait_expired_o,
   output logic            rerun_expired_o
);

   cfg_tail_pkg::sup_state_t st_r;
   cfg_tail_pkg::sup_state_t st_nxt;
   logic [12:0]              wait_limit;
   logic [12:0]              wait_next;
   logic [7:0]               rerun_next;

   assign wait_limit = {target_wait_limit_i, `WAIT_LOW_ZEROS};
   assign wait_next  = (st_r.wait_cnt == `WAIT_CNT_MAX) ? st_r.wait_cnt : st_r.wait_cnt + 13'h0001;
   assign rerun_next = (st_r.rerun_cnt == `RERUN_CNT_MAX) ? st_r.rerun_cnt : st_r.rerun_cnt + 8'h01;

   always_comb begin
      st_nxt = st_r;
      st_nxt.wait_expired  = 1'b0;
      st_nxt.rerun_expired = 1'b0;
      if (trdy_wait_i) begin
         st_nxt.wait_cnt = wait_next;
         if (target_wait_limit_i != `LIMIT_OFF && wait_next > wait_limit && !st_r.wait_fired) begin
            st_nxt.wait_expired = 1'b1;
            st_nxt.wait_fired   = 1'b1;
         end
      end else begin
         st_nxt.wait_cnt   = 13'h0000;
         st_nxt.wait_fired = 1'b0;
      end
      if (retry_i) begin
         st_nxt.rerun_cnt = rerun_next;
         if (rerun_limit_i != `LIMIT_OFF && rerun_next > rerun_limit_i && !st_r.rerun_fired) begin
            st_nxt.rerun_expired = 1'b1;
            st_nxt.rerun_fired   = 1'b1;
         end
      end
      if (xfer_done_i) begin
         st_nxt.rerun_cnt   = 8'h00;
         st_nxt.rerun_fired = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wait_expired_o  = st_r.wait_expired;
   assign rerun_expired_o = st_r.rerun_expired;

endmodule : wait_supervisor

// ### hdl/pci_config_header_tail.sv
`timescale 1ns/100ps
`include "cfg_tail_regs.svh"

module pci_config_header_tail #(
   // arbitrary neutral identity values
   parameter logic [15:0] SUBSYS_VENDOR_CODE = 16'h5a5a,
   parameter logic [15:0] OHCI_SUBSYS_CODE   = 16'h0a01,
   parameter logic [15:0] EHCI_SUBSYS_CODE   = 16'h0a02,
   parameter bit          IS_EHCI            = 1'b0
) (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        cfg_req_i,
   input  wire logic        cfg_we_i,
   input  wire logic [7:0]  cfg_addr_i,
   input  wire logic [3:0]  cfg_be_i,
   input  wire logic [31:0] cfg_wdata_i,
   output logic [31:0]      cfg_rdata_o,
   output logic             cfg_ack_o,
   input  wire logic        trdy_wait_i,
   input  wire logic        retry_i,
   input  wire logic        xfer_done_i,
   input  wire logic        fatal_clear_i,
   output logic             fatal_bus_error_flag_o,
   output logic             capability_list_flag_o,
   output logic [7:0]       irq_routing_number_o,
   output logic [15:0]      burst_hint_cyc_o,
   output logic [15:0]      interval_hint_cyc_o,
   output logic             latency_demand_o
);

   cfg_tail_pkg::bank_state_t st_r;
   cfg_tail_pkg::bank_state_t st_nxt;

   logic [15:0] subsys_code;
   logic [7:0]  burst_hint;
   logic [7:0]  interval_hint;
   logic [7:0]  cap_pointer;
   logic [5:0]  word_sel;
   logic        sel_subsys;
   logic        sel_cap;
   logic        sel_irq;
   logic        sel_limits;
   logic        wr;
   logic        wait_expired;
   logic        rerun_expired;
   logic [31:0] read_word;

   assign subsys_code   = IS_EHCI ? EHCI_SUBSYS_CODE : OHCI_SUBSYS_CODE;
   assign burst_hint    = IS_EHCI ? `EHCI_BURST_HINT : `OHCI_BURST_HINT;
   assign interval_hint = IS_EHCI ? `EHCI_INTERVAL_HINT : `OHCI_INTERVAL_HINT;
   assign cap_pointer   = `CAP_POINTER_VAL & `CAP_RSVD_MASK;

   assign word_sel   = cfg_addr_i[7:2];
   assign sel_subsys = word_sel == 6'(`OFS_SUBSYS_VENDOR >> 2);
   assign sel_cap    = word_sel == 6'(`OFS_CAP_POINTER >> 2);
   assign sel_irq    = word_sel == 6'(`OFS_IRQ_ROUTING >> 2);
   assign sel_limits = word_sel == 6'(`OFS_TARGET_WAIT >> 2);
   assign wr         = cfg_req_i && cfg_we_i;

   // read mux, one aligned dword per offset group
   always_comb begin
      read_word = 32'h0000_0000;
      if (sel_subsys) begin
         read_word = {subsys_code, SUBSYS_VENDOR_CODE};
      end else if (sel_cap) begin
         read_word = {`ZERO_HALF, `ZERO_BYTE, cap_pointer};
      end else if (sel_irq) begin
         read_word = {interval_hint, burst_hint, `IRQ_PIN_VAL, st_r.irq_routing_number};
      end else if (sel_limits) begin
         read_word = {`ZERO_HALF, st_r.rerun_limit, st_r.target_wait_limit};
      end
   end

   wait_supervisor u_sup (
      .clk_i               (clk_i),
      .rstn_i              (rstn_i),
      .target_wait_limit_i (st_r.target_wait_limit),
      .rerun_limit_i       (st_r.rerun_limit),
      .trdy_wait_i         (trdy_wait_i),
      .retry_i             (retry_i),
      .xfer_done_i         (xfer_done_i),
      .wait_expired_o      (wait_expired),
      .rerun_expired_o     (rerun_expired)
   );

   always_comb begin
      st_nxt     = st_r;
      st_nxt.ack = cfg_req_i;
      if (cfg_req_i && !cfg_we_i) begin
         st_nxt.rdata = read_word;
      end
      if (wr && sel_irq && cfg_be_i[0]) begin
         st_nxt.irq_routing_number = cfg_wdata_i[7:0];
      end
      if (wr && sel_limits && cfg_be_i[0]) begin
         st_nxt.target_wait_limit = cfg_wdata_i[7:0];
      end
      if (wr && sel_limits && cfg_be_i[1]) begin
         st_nxt.rerun_limit = cfg_wdata_i[15:8];
      end
      if (fatal_clear_i) begin
         st_nxt.fatal_bus_error_flag = 1'b0;
      end
      if (wait_expired || rerun_expired) begin
         st_nxt.fatal_bus_error_flag = 1'b1;
      end
      st_nxt.capability_list_flag = 1'b1;
      st_nxt.burst_cyc    = 16'(burst_hint * `HINT_UNIT_CYC);
      st_nxt.interval_cyc = 16'(interval_hint * `HINT_UNIT_CYC);
      st_nxt.latency_demand = (burst_hint != `ZERO_BYTE) || (interval_hint != `ZERO_BYTE);
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r                      <= '0;
         st_r.irq_routing_number   <= `IRQ_ROUTING_RST;
         st_r.target_wait_limit    <= `TARGET_WAIT_RST;
         st_r.rerun_limit          <= `RERUN_LIMIT_RST;
         st_r.capability_list_flag <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cfg_rdata_o            = st_r.rdata;
   assign cfg_ack_o              = st_r.ack;
   assign fatal_bus_error_flag_o = st_r.fatal_bus_error_flag;
   assign capability_list_flag_o = st_r.capability_list_flag;
   assign irq_routing_number_o   = st_r.irq_routing_number;
   assign burst_hint_cyc_o       = st_r.burst_cyc;
   assign interval_hint_cyc_o    = st_r.interval_cyc;
   assign latency_demand_o       = st_r.latency_demand;

   // checks
   default clocking cb @(posedge clk_i);
   endclocking

   default disable iff (!rstn_i);

   logic [12:0] wait_run_r;
   logic [7:0]  retry_run_r;

   // helper: consecutive target-ready wait cycles and retries per transfer
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wait_run_r <= 13'h0000;
      end else if (!trdy_wait_i) begin
         wait_run_r <= 13'h0000;
      end else if (wait_run_r != `WAIT_CNT_MAX) begin
         wait_run_r <= wait_run_r + 13'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         retry_run_r <= 8'h00;
      end else if (xfer_done_i) begin
         retry_run_r <= 8'h00;
      end else if (retry_i && retry_run_r != `RERUN_CNT_MAX) begin
         retry_run_r <= retry_run_r + 8'h01;
      end
   end

   subsys_read_a: assert property (
      cfg_req_i && !cfg_we_i && sel_subsys |=>
         cfg_ack_o && cfg_rdata_o == {subsys_code, SUBSYS_VENDOR_CODE})
      else $error("subsystem identity read wrong");

   cap_pointer_a: assert property (
      cfg_req_i && !cfg_we_i && sel_cap |=>
         cfg_rdata_o[7:0] == `CAP_POINTER_VAL && cfg_rdata_o[1:0] == 2'h0
         && cfg_rdata_o[31:8] == 24'h00_0000)
      else $error("capability pointer read wrong");

   cap_flag_a: assert property (
      capability_list_flag_o)
      else $error("capability list flag dropped");

   irq_word_a: assert property (
      cfg_req_i && !cfg_we_i && sel_irq |=>
         cfg_rdata_o[31:8] == {interval_hint, burst_hint, `IRQ_PIN_VAL})
      else $error("fixed interrupt or hint bytes read wrong");

   irq_write_a: assert property (
      wr && sel_irq && cfg_be_i[0] ##1 cfg_req_i && !cfg_we_i && sel_irq |=>
         cfg_rdata_o[7:0] == $past(cfg_wdata_i[7:0], 2))
      else $error("routing byte readback wrong");

   ro_write_a: assert property (
      wr && !(sel_irq && cfg_be_i[0]) |=> $stable(irq_routing_number_o))
      else $error("routing byte changed without its write");

   limit_write_a: assert property (
      wr && sel_limits && cfg_be_i[1] && !cfg_be_i[0] |=>
         st_r.rerun_limit == $past(cfg_wdata_i[15:8])
         && $stable(st_r.target_wait_limit))
      else $error("limit register lane handling wrong");

   wait_expiry_a: assert property (
      wait_expired |-> $past(st_r.target_wait_limit) != `LIMIT_OFF
         && wait_run_r > {$past(st_r.target_wait_limit), `WAIT_LOW_ZEROS})
      else $error("target wait expiry at wrong count");

   wait_off_a: assert property (
      st_r.target_wait_limit == `LIMIT_OFF && $past(st_r.target_wait_limit) == `LIMIT_OFF
         |-> !wait_expired)
      else $error("wait expiry while disabled");

   rerun_expiry_a: assert property (
      rerun_expired |-> $past(retry_i) && $past(st_r.rerun_limit) != `LIMIT_OFF
         && retry_run_r > $past(st_r.rerun_limit))
      else $error("retry expiry without excess retries");

   fatal_set_a: assert property (
      wait_expired || rerun_expired |=> fatal_bus_error_flag_o ##1
         (fatal_bus_error_flag_o || $past(fatal_clear_i)))
      else $error("fatal error flag not set or not held");

   hint_scale_a: assert property (
      $past(rstn_i) |-> burst_hint_cyc_o == 16'(burst_hint * `HINT_UNIT_CYC)
         && latency_demand_o == (burst_hint != `ZERO_BYTE || interval_hint != `ZERO_BYTE))
      else $error("hint cycles or demand wrong");

   interval_scale_a: assert property (
      $past(rstn_i) |->
         interval_hint_cyc_o == 16'(interval_hint * `HINT_UNIT_CYC))
      else $error("interval hint cycles wrong");

   ack_timing_a: assert property (
      cfg_ack_o == $past(cfg_req_i))
      else $error("access acknowledge timing wrong");

   rdata_hold_a: assert property (
      !(cfg_req_i && !cfg_we_i) |=> $stable(cfg_rdata_o))
      else $error("read data changed without a read");

   unmapped_read_a: assert property (
      cfg_req_i && !cfg_we_i && !sel_subsys && !sel_cap && !sel_irq && !sel_limits |=>
         cfg_rdata_o == {`ZERO_HALF, `ZERO_HALF})
      else $error("unmapped dword read not zero");

   limits_read_a: assert property (
      cfg_req_i && !cfg_we_i && sel_limits |=>
         cfg_rdata_o == {`ZERO_HALF, $past(st_r.rerun_limit), $past(st_r.target_wait_limit)})
      else $error("limit registers read wrong");

   wait_write_a: assert property (
      wr && sel_limits && cfg_be_i[0] |=>
         st_r.target_wait_limit == $past(cfg_wdata_i[7:0]))
      else $error("target wait limit write lost");

   irq_route_a: assert property (
      wr && sel_irq && cfg_be_i[0] |=>
         irq_routing_number_o == $past(cfg_wdata_i[7:0]))
      else $error("routing byte output wrong");

   rerun_off_a: assert property (
      st_r.rerun_limit == `LIMIT_OFF && $past(st_r.rerun_limit) == `LIMIT_OFF
         |-> !rerun_expired)
      else $error("retry expiry while disabled");

   wait_once_a: assert property (
      wait_expired |=> !wait_expired)
      else $error("target wait expiry repeated");

   rerun_once_a: assert property (
      rerun_expired |=> !rerun_expired)
      else $error("retry expiry repeated");

   fatal_hold_a: assert property (
      !fatal_bus_error_flag_o && !wait_expired && !rerun_expired |=>
         !fatal_bus_error_flag_o)
      else $error("fatal error flag set without expiry");

   fatal_clear_a: assert property (
      fatal_clear_i && !wait_expired && !rerun_expired |=>
         !fatal_bus_error_flag_o)
      else $error("fatal error flag not cleared");

   wait_timeout_c: cover property (
      wait_expired ##1 fatal_bus_error_flag_o);

   rerun_timeout_c: cover property (
      rerun_expired ##1 fatal_bus_error_flag_o);

   irq_write_c: cover property (
      wr && sel_irq && cfg_be_i[0] ##1 cfg_req_i && !cfg_we_i && sel_irq);

   clear_race_c: cover property (
      fatal_clear_i && (wait_expired || rerun_expired));

   rerun_lane_c: cover property (
      wr && sel_limits && cfg_be_i[1] && !cfg_be_i[0]);

endmodule : pci_config_header_tail

// ### dv/bus_target_model.sv
`timescale 1ns/100ps

module bus_target_model (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        start_i,
   input  wire logic [12:0] wait_len_i,
   input  wire logic [8:0]  retries_i,
   output logic             trdy_wait_o,
   output logic             retry_o,
   output logic             xfer_done_o,
   output logic             busy_o
);
   logic [12:0] wait_cnt;
   logic [8:0]  retry_cnt;

   // target side of one own-master transfer: stall, then retries, then end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trdy_wait_o <= 1'b0;
         retry_o     <= 1'b0;
         xfer_done_o <= 1'b0;
         busy_o      <= 1'b0;
         wait_cnt    <= 13'h0000;
         retry_cnt   <= 9'h000;
      end else begin
         retry_o     <= 1'b0;
         xfer_done_o <= 1'b0;
         if (start_i && !busy_o) begin
            busy_o      <= 1'b1;
            wait_cnt    <= wait_len_i;
            retry_cnt   <= retries_i;
            trdy_wait_o <= (wait_len_i != 13'h0000);
         end else if (busy_o) begin
            if (wait_cnt > 13'h0001) begin
               wait_cnt <= wait_cnt - 13'h0001;
            end else if (wait_cnt == 13'h0001) begin
               wait_cnt    <= 13'h0000;
               trdy_wait_o <= 1'b0;
            end else if (retry_cnt != 9'h000) begin
               retry_o   <= 1'b1;
               retry_cnt <= retry_cnt - 9'h001;
            end else begin
               xfer_done_o <= 1'b1;
               busy_o      <= 1'b0;
            end
         end
      end
   end
endmodule : bus_target_model

// ### dv/pci_config_header_tail_test.sv
`timescale 1ns/100ps

module pci_config_header_tail_test;
   // arbitrary neutral identity values
   localparam logic [15:0] VEND        = 16'h3c3c;
   localparam logic [15:0] OCODE       = 16'h0b01;
   localparam logic [15:0] ECODE       = 16'h0b02;
   localparam int          TIMEOUT_CYC = 20000;

   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        cfg_req_i = 1'b0;
   logic        cfg_we_i = 1'b0;
   logic [7:0]  cfg_addr_i = 8'h00;
   logic [3:0]  cfg_be_i = 4'h0;
   logic [31:0] cfg_wdata_i = 32'h00000000;
   logic        fatal_clear_i = 1'b0;
   logic        start = 1'b0;
   logic [12:0] wait_len = 13'h0000;
   logic [8:0]  retries = 9'h000;
   logic [31:0] cfg_rdata_o, e_rdata, rd, erd;
   logic        cfg_ack_o, fatal_bus_error_flag_o, capability_list_flag_o, latency_demand_o;
   logic [7:0]  irq_routing_number_o, lim;
   logic [15:0] burst_hint_cyc_o, interval_hint_cyc_o, e_burst, e_interval;
   logic        trdy_wait, retry, xfer_done, busy, e_fatal;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cycles = 0;

   always #2 clk_i = ~clk_i;

   pci_config_header_tail #(.SUBSYS_VENDOR_CODE(VEND), .OHCI_SUBSYS_CODE(OCODE),
      .EHCI_SUBSYS_CODE(ECODE), .IS_EHCI(1'b0)) dut (
      .clk_i(clk_i), .rstn_i(rstn_i), .cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i),
      .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o), .trdy_wait_i(trdy_wait),
      .retry_i(retry), .xfer_done_i(xfer_done), .fatal_clear_i(fatal_clear_i),
      .fatal_bus_error_flag_o(fatal_bus_error_flag_o),
      .capability_list_flag_o(capability_list_flag_o),
      .irq_routing_number_o(irq_routing_number_o), .burst_hint_cyc_o(burst_hint_cyc_o),
      .interval_hint_cyc_o(interval_hint_cyc_o), .latency_demand_o(latency_demand_o));

   pci_config_header_tail #(.SUBSYS_VENDOR_CODE(VEND), .OHCI_SUBSYS_CODE(OCODE),
      .EHCI_SUBSYS_CODE(ECODE), .IS_EHCI(1'b1)) dut_ehci (
      .clk_i(clk_i), .rstn_i(rstn_i), .cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i),
      .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(e_rdata), .cfg_ack_o(), .trdy_wait_i(trdy_wait), .retry_i(retry),
      .xfer_done_i(xfer_done), .fatal_clear_i(fatal_clear_i),
      .fatal_bus_error_flag_o(e_fatal),
      .capability_list_flag_o(), .irq_routing_number_o(), .burst_hint_cyc_o(e_burst),
      .interval_hint_cyc_o(e_interval), .latency_demand_o());

   bus_target_model target (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start),
      .wait_len_i(wait_len), .retries_i(retries), .trdy_wait_o(trdy_wait),
      .retry_o(retry), .xfer_done_o(xfer_done), .busy_o(busy));

   task automatic end_of_test();
      if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic reset_dut();
      @(negedge clk_i);
      rstn_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rstn_i = 1'b1;
   endtask : reset_dut

   task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b,
                         input logic [31:0] d);
      int n;
      @(negedge clk_i);
      cfg_req_i   = 1'b1;
      cfg_we_i    = w;
      cfg_addr_i  = a;
      cfg_be_i    = b;
      cfg_wdata_i = d;
      @(negedge clk_i);
      cfg_req_i = 1'b0;
      n = 0;
      while (cfg_ack_o !== 1'b1 && n < 4) begin
         @(negedge clk_i);
         n++;
      end
      chk_bit("cfg_ack_o", 1'b1, cfg_ack_o);
      rd  = cfg_rdata_o;
      erd = e_rdata;
   endtask : access

   task automatic read(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] eexp);
      access(1'b0, a, 4'hf, 32'h00000000);
      chk_word("cfg_rdata_o", exp, rd);
      chk_word("ehci cfg_rdata_o", eexp, erd);
   endtask : read

   task automatic wr_rd(input logic [31:0] d, input logic [31:0] exp, input logic [31:0] eexp);
      @(negedge clk_i);
      cfg_req_i   = 1'b1;
      cfg_we_i    = 1'b1;
      cfg_addr_i  = 8'h3c;
      cfg_be_i    = 4'h1;
      cfg_wdata_i = d;
      @(negedge clk_i);
      cfg_we_i = 1'b0;
      @(negedge clk_i);
      cfg_req_i = 1'b0;
      chk_bit("cfg_ack_o", 1'b1, cfg_ack_o);
      chk_word("cfg_rdata_o", exp, cfg_rdata_o);
      chk_word("ehci cfg_rdata_o", eexp, e_rdata);
   endtask : wr_rd

   task automatic run_xfer(input logic [12:0] wl, input logic [8:0] rt, input logic fatal);
      int n;
      @(negedge clk_i);
      start    = 1'b1;
      wait_len = wl;
      retries  = rt;
      @(negedge clk_i);
      start = 1'b0;
      n = 0;
      while (busy === 1'b1 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      chk_bit("target idle", 1'b0, busy);
      repeat (4) @(negedge clk_i);
      chk_bit("fatal_bus_error_flag_o", fatal, fatal_bus_error_flag_o);
      chk_bit("ehci fatal flag", fatal, e_fatal);
      fatal_clear_i = 1'b1;
      @(negedge clk_i);
      fatal_clear_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk_bit("fatal flag cleared", 1'b0, fatal_bus_error_flag_o);
      chk_bit("ehci fatal flag cleared", 1'b0, e_fatal);
   endtask : run_xfer

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == TIMEOUT_CYC) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      reset_dut();
      read(8'h2c, {OCODE, VEND}, {ECODE, VEND});
      read(8'h34, 32'h000000dc, 32'h000000dc);
      // masked pointer, as host software uses it
      chk_word("capability pointer", 32'h000000dc, rd & 32'h000000fc);
      chk_bit("capability_list_flag_o", 1'b1, capability_list_flag_o);
      read(8'h3c, 32'h2a010100, 32'h10020100);
      read(8'h40, 32'h00008000, 32'h00008000);
      chk_word("burst_hint_cyc_o", 32'd62, {16'h0000, burst_hint_cyc_o});
      chk_word("interval_hint_cyc_o", 32'd2604, {16'h0000, interval_hint_cyc_o});
      chk_word("ehci burst hint", 32'd124, {16'h0000, e_burst});
      chk_word("ehci interval hint", 32'd992, {16'h0000, e_interval});
      chk_bit("latency_demand_o", 1'b1, latency_demand_o);
      access(1'b1, 8'h2c, 4'hf, 32'hffffffff);
      access(1'b1, 8'h34, 4'hf, 32'hffffffff);
      access(1'b1, 8'h3c, 4'hf, 32'hffffffff);
      access(1'b1, 8'h50, 4'hf, 32'hffffffff);
      read(8'h2c, {OCODE, VEND}, {ECODE, VEND});
      read(8'h34, 32'h000000dc, 32'h000000dc);
      read(8'h3c, 32'h2a0101ff, 32'h100201ff);
      chk_word("irq_routing_number_o", 32'h000000ff, {24'h000000, irq_routing_number_o});
      wr_rd(32'h0000005a, 32'h2a01015a, 32'h1002015a);
      read(8'h50, 32'h00000000, 32'h00000000);
      for (int i = 1; i <= 2; i++) begin
         lim = 8'(i);
         access(1'b1, 8'h40, 4'h1, {24'h000000, lim});
         read(8'h40, {16'h0000, 8'h80, lim}, {16'h0000, 8'h80, lim});
         run_xfer({lim, 5'h00}, 9'h000, 1'b0);
         run_xfer({lim, 5'h00} + 13'h0001, 9'h000, 1'b1);
      end
      access(1'b1, 8'h40, 4'h1, 32'h00000000);
      run_xfer(13'd300, 9'h000, 1'b0);
      run_xfer(13'h0000, 9'd128, 1'b0);
      run_xfer(13'h0000, 9'd129, 1'b1);
      access(1'b1, 8'h40, 4'h2, 32'h00000000);
      read(8'h40, 32'h00000000, 32'h00000000);
      run_xfer(13'h0000, 9'd200, 1'b0);
      access(1'b1, 8'h40, 4'h3, 32'h00001122);
      reset_dut();
      read(8'h3c, 32'h2a010100, 32'h10020100);
      read(8'h40, 32'h00008000, 32'h00008000);
      end_of_test();
   end
endmodule : pci_config_header_tail_test
